// *** shared/cps_pkg.sv ***
// Shared constants and types of the configuration pin sequencer.
// Assumes a 20 MHz core clock; all counts below are in core clock cycles.
package cps_pkg;
    // Core clock rate
    localparam int unsigned CLK_MHZ = 20;
    // Extra master wait after the init line rises, in microseconds
    localparam int unsigned MASTER_WAIT_MIN_US = 30;
    localparam int unsigned MASTER_WAIT_MAX_US = 300;
    // Least time of the window; a whole number of cycles at this rate
    localparam int unsigned MASTER_WAIT_CYCLES = MASTER_WAIT_MIN_US * CLK_MHZ;
    // Length of one clear pass of the configuration memory
    localparam int unsigned CLEAR_PASS_CYCLES = 64;
    // Half period of the generated configuration clock in master mode
    localparam int unsigned CFG_CLK_HALF_CYCLES = 4;
    // Width of the shared interval counter
    localparam int unsigned CNT_W = 16;
    // Mode pin codes {m1, m0}; the remaining code loads as slave serial
    localparam logic [1:0] MODE_MASTER_SERIAL = 2'h0;
    localparam logic [1:0] MODE_EXPRESS = 2'h2;
    localparam logic [1:0] MODE_SLAVE_SERIAL = 2'h3;
    // Reset values
    localparam logic [1:0] MODE_RESET = 2'h3;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Position of each pin within the synchroniser vector
    localparam int unsigned SY_PROG = 0;
    localparam int unsigned SY_INIT = 1;
    localparam int unsigned SY_MODE = 2;
    localparam int unsigned SY_CFG_CLK = 4;
    localparam int unsigned SY_DIN = 5;
    localparam int unsigned SY_SEL = 6;
    localparam int unsigned SY_BYTE = 7;
    localparam int unsigned SY_TDI = 15;
    localparam int unsigned SY_TCK = 16;
    localparam int unsigned SY_TMS = 17;
    localparam int unsigned SY_W = 18;

    // Sequencer states
    typedef enum logic [2:0] {
        CPS_CLEAR = 3'b000,
        CPS_WAIT = 3'b001,
        CPS_DELAY = 3'b010,
        CPS_LOAD = 3'b011,
        CPS_ERROR = 3'b100,
        CPS_USER = 3'b101
    } cps_state_t;
endpackage

// *** core/cps_top.sv ***
// Configuration pin sequencer: clear, wait, mode capture, data intake, release.
// Assumes all pins are asynchronous to clock; error and done come from core logic.
// Function
// - High busy pin high until user mode
// - Low busy pin low until user mode
// - Init driven low during power-up and clearing
// - Master waits extra 30-300 us
// - Data error pulls init low
// - Init becomes user pin after configuration
// - Serial data sampled on rising config clock
// - Express mode takes eight-bit parallel bytes
// - Chain select gates express byte intake
// - Unused scan frees test pins to user
// - Used scan feeds test pins to TAP
// - Program low restarts clearing; after release two passes, then wait
// - Mode pins sampled after init rises
// - Serial forward on falling edge, 1.5 periods
`timescale 1ns/1ps
`default_nettype none
module cps_top #(
    parameter int unsigned CLEAR_CYCLES = cps_pkg::CLEAR_PASS_CYCLES,
    parameter int unsigned WAIT_CYCLES = cps_pkg::MASTER_WAIT_CYCLES,
    parameter int unsigned HALF_CYCLES = cps_pkg::CFG_CLK_HALF_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control pins
    input wire logic program_n,
    input wire logic [1:0] mode_pins,
    // Init line, open drain
    input wire logic init_i,
    output logic init_o,
    output logic init_oe,
    // Configuration clock, output in master mode
    input wire logic cfg_clock_i,
    output logic cfg_clock_o,
    output logic cfg_clock_oe,
    // Configuration data pins
    input wire logic serial_in,
    input wire logic chain_select,
    input wire logic [7:0] cfg_byte_bus,
    output logic serial_out,
    output logic serial_out_oe,
    // Busy indicators
    output logic cfg_busy_high,
    output logic cfg_busy_high_oe,
    output logic cfg_busy_low,
    output logic cfg_busy_low_oe,
    // Test pins
    input wire logic tdi_pin,
    input wire logic tck_pin,
    input wire logic tms_pin,
    // Core side of configuration
    input wire logic cfg_error,
    input wire logic cfg_done,
    input wire logic scan_primitive,
    output logic [7:0] cfg_byte,
    output logic cfg_byte_valid,
    output logic [1:0] cfg_mode,
    output cps_pkg::cps_state_t cfg_state,
    // User logic side of the shared pins
    input wire logic user_init_o,
    input wire logic user_init_oe,
    input wire logic user_high_o,
    input wire logic user_high_oe,
    input wire logic user_low_o,
    input wire logic user_low_oe,
    input wire logic user_dout_o,
    input wire logic user_dout_oe,
    output logic tap_enable,
    output logic tap_tdi,
    output logic tap_tck,
    output logic tap_tms,
    output logic user_tdi,
    output logic user_tck,
    output logic user_tms
);
    import cps_pkg::*;

    logic rst_meta_q;
    logic rst_sync_q;
    logic [SY_W-1:0] pin_meta_q;
    logic [SY_W-1:0] pin_q;
    cps_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic finish_q;
    logic [1:0] mode_q;
    logic [CNT_W-1:0] div_q;
    logic mclk_q;
    logic clk_pin_prev_q;
    logic [7:0] shift_q;
    logic [2:0] bit_q;
    logic [7:0] byte_q;
    logic valid_q;
    logic fwd1_q;
    logic fwd2_q;
    logic dout_q;
    logic master_w;
    logic serial_w;
    logic in_user_w;
    logic div_end_w;
    logic rise_w;
    logic fall_w;

    // Release of reset through two stages
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Two-stage synchroniser; only pin_q is read by logic
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pin_meta_q <= '0;
            pin_q <= '0;
        end else begin
            pin_meta_q <= {tms_pin, tck_pin, tdi_pin, cfg_byte_bus, chain_select, serial_in,
                           cfg_clock_i, mode_pins, init_i, program_n};
            pin_q <= pin_meta_q;
        end
    end

    assign master_w = (mode_q == MODE_MASTER_SERIAL);
    assign serial_w = (mode_q != MODE_EXPRESS);
    assign in_user_w = (state_q == CPS_USER);
    assign div_end_w = (div_q == CNT_W'(HALF_CYCLES - 1));

    // Clock edges: own divider in master mode, sampled pin otherwise
    assign rise_w = master_w ? (div_end_w && !mclk_q) : (pin_q[SY_CFG_CLK] && !clk_pin_prev_q);
    assign fall_w = master_w ? (div_end_w && mclk_q) : (!pin_q[SY_CFG_CLK] && clk_pin_prev_q);

    // Sequencer; a low program pin restarts clearing from any state
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= CPS_CLEAR;
            cnt_q <= '0;
            finish_q <= 1'b0;
            mode_q <= MODE_RESET;
        end else if (!pin_q[SY_PROG]) begin
            state_q <= CPS_CLEAR;
            cnt_q <= '0;
            finish_q <= 1'b0;
        end else begin
            case (state_q)
                CPS_CLEAR: begin
                    // Pass in progress completes, then exactly one more
                    if (cnt_q == CNT_W'(CLEAR_CYCLES - 1)) begin
                        cnt_q <= '0;
                        if (finish_q) begin
                            state_q <= CPS_WAIT;
                        end else begin
                            finish_q <= 1'b1;
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                CPS_WAIT: begin
                    // Held here while anyone pulls init low
                    if (pin_q[SY_INIT]) begin
                        mode_q <= pin_q[SY_MODE+1:SY_MODE];
                        cnt_q <= '0;
                        if (pin_q[SY_MODE+1:SY_MODE] == MODE_MASTER_SERIAL) begin
                            state_q <= CPS_DELAY;
                        end else begin
                            state_q <= CPS_LOAD;
                        end
                    end
                end
                CPS_DELAY: begin
                    // Minimum of the window, safely inside the upper bound
                    if (cnt_q == CNT_W'(WAIT_CYCLES - 1)) begin
                        state_q <= CPS_LOAD;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                CPS_LOAD: begin
                    if (cfg_error) begin
                        state_q <= CPS_ERROR;
                    end else if (cfg_done) begin
                        state_q <= CPS_USER;
                    end
                end
                CPS_ERROR: state_q <= CPS_ERROR; // Left only by a program request
                CPS_USER: state_q <= CPS_USER;
                default: state_q <= CPS_CLEAR;
            endcase
        end
    end

    // Master clock divider, runs only while loading
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            div_q <= '0;
            mclk_q <= 1'b0;
            clk_pin_prev_q <= 1'b0;
        end else begin
            clk_pin_prev_q <= pin_q[SY_CFG_CLK];
            if (state_q != CPS_LOAD || div_end_w) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + 1'b1;
            end
            if (state_q != CPS_LOAD) begin
                mclk_q <= 1'b0;
            end else if (div_end_w) begin
                mclk_q <= !mclk_q;
            end
        end
    end

    // Data intake, only in the loading state so errors stop it
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            shift_q <= BYTE_RESET;
            bit_q <= 3'h0;
            byte_q <= BYTE_RESET;
            valid_q <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            if (state_q != CPS_LOAD) begin
                bit_q <= 3'h0;
            end else if (rise_w && serial_w) begin
                // MSB first, one bit per rising edge
                shift_q <= {shift_q[6:0], pin_q[SY_DIN]};
                bit_q <= bit_q + 1'b1;
                if (bit_q == 3'h7) begin
                    byte_q <= {shift_q[6:0], pin_q[SY_DIN]};
                    valid_q <= 1'b1;
                end
            end else if (rise_w && pin_q[SY_SEL]) begin
                // Whole byte per rising edge while selected
                byte_q <= pin_q[SY_BYTE+7:SY_BYTE];
                valid_q <= 1'b1;
            end
        end
    end

    // Forwarding pipe: two rising edges, then out on the falling one
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            fwd1_q <= 1'b0;
            fwd2_q <= 1'b0;
            dout_q <= 1'b0;
        end else if (state_q == CPS_LOAD) begin
            if (rise_w) begin
                fwd1_q <= pin_q[SY_DIN];
                fwd2_q <= fwd1_q;
            end
            if (fall_w) begin
                dout_q <= fwd2_q;
            end
        end
    end

    // Shared pins; user logic takes all but the configuration clock over once configured
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            init_o <= 1'b0;
            init_oe <= 1'b1;
            cfg_busy_high <= 1'b1;
            cfg_busy_high_oe <= 1'b1;
            cfg_busy_low <= 1'b0;
            cfg_busy_low_oe <= 1'b1;
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
            cfg_clock_o <= 1'b0;
            cfg_clock_oe <= 1'b0;
        end else begin
            // Low while clearing or after an error, released otherwise
            init_o <= in_user_w ? user_init_o : 1'b0;
            init_oe <= in_user_w ? user_init_oe : (state_q == CPS_CLEAR || state_q == CPS_ERROR);
            cfg_busy_high <= in_user_w ? user_high_o : 1'b1;
            cfg_busy_high_oe <= in_user_w ? user_high_oe : 1'b1;
            cfg_busy_low <= in_user_w ? user_low_o : 1'b0;
            cfg_busy_low_oe <= in_user_w ? user_low_oe : 1'b1;
            serial_out <= in_user_w ? user_dout_o : dout_q;
            serial_out_oe <= in_user_w ? user_dout_oe : (state_q == CPS_LOAD && serial_w);
            cfg_clock_o <= mclk_q;
            cfg_clock_oe <= (state_q == CPS_LOAD) && master_w;
        end
    end

    // Test pins: TAP always before user mode, then only if scan is placed
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            tap_enable <= 1'b1;
            tap_tdi <= 1'b0;
            tap_tck <= 1'b0;
            tap_tms <= 1'b0;
            user_tdi <= 1'b0;
            user_tck <= 1'b0;
            user_tms <= 1'b0;
        end else begin
            tap_enable <= !in_user_w || scan_primitive;
            tap_tdi <= pin_q[SY_TDI] && (!in_user_w || scan_primitive);
            tap_tck <= pin_q[SY_TCK] && (!in_user_w || scan_primitive);
            tap_tms <= pin_q[SY_TMS] && (!in_user_w || scan_primitive);
            user_tdi <= pin_q[SY_TDI] && in_user_w && !scan_primitive;
            user_tck <= pin_q[SY_TCK] && in_user_w && !scan_primitive;
            user_tms <= pin_q[SY_TMS] && in_user_w && !scan_primitive;
        end
    end

    // Core side status
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            cfg_byte <= BYTE_RESET;
            cfg_byte_valid <= 1'b0;
            cfg_mode <= MODE_RESET;
            cfg_state <= CPS_CLEAR;
        end else begin
            cfg_byte <= byte_q;
            cfg_byte_valid <= valid_q;
            cfg_mode <= mode_q;
            cfg_state <= state_q;
        end
    end
endmodule
`default_nettype wire

// *** sim/cps_checker.sv ***
// Port-level checks of the pin sequencer.
// Assumes one clock domain; bound into cps_top below.
`timescale 1ns/1ps
`default_nettype none
module cps_checker #(
    parameter int unsigned CLEAR_CYCLES = 4,
    parameter int unsigned WAIT_CYCLES = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Watched ports
    input wire logic program_n,
    input wire logic init_o,
    input wire logic init_oe,
    input wire logic cfg_busy_high,
    input wire logic cfg_busy_low,
    input wire logic cfg_error,
    input wire logic scan_primitive,
    input wire logic tap_enable,
    input wire logic user_init_o,
    input wire logic user_init_oe,
    input wire cps_pkg::cps_state_t cfg_state
);
    import cps_pkg::*;
    localparam int CLR_MAX = 2 * CLEAR_CYCLES + 8;
    logic [15:0] dly_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Cycles of the current master wait; holds its length for one cycle after it, zero otherwise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dly_q <= 16'h0000;
        end else begin
            dly_q <= (cfg_state == CPS_DELAY) ? dly_q + 16'h0001 : 16'h0000;
        end
    end
    busy_high_a: assert property (cfg_state != CPS_USER |-> cfg_busy_high)
        else $error("high busy pin low before user mode");
    busy_low_a: assert property (cfg_state != CPS_USER |-> !cfg_busy_low)
        else $error("low busy pin high before user mode");
    init_clear_a: assert property ((cfg_state == CPS_CLEAR) [*2] |-> init_oe && !init_o)
        else $error("init not pulled low while clearing");
    error_init_a: assert property ((cfg_state == CPS_ERROR) [*2] |-> init_oe && !init_o)
        else $error("init not pulled low after data error");
    error_entry_a: assert property (cfg_state == CPS_LOAD && cfg_error |-> ##2 cfg_state == CPS_ERROR)
        else $error("data error did not stop loading");
    master_wait_a: assert property (cfg_state == CPS_LOAD && dly_q != 16'h0000 |->
        dly_q >= WAIT_CYCLES && dly_q <= WAIT_CYCLES + 2) else $error("master wait length wrong");
    program_wait_a: assert property ($rose(program_n) |-> ##[1:CLR_MAX] cfg_state == CPS_WAIT)
        else $error("no wait state after program release");
    user_init_a: assert property (cfg_state == CPS_USER ##1 cfg_state == CPS_USER |->
        init_oe == $past(user_init_oe) && init_o == $past(user_init_o)) else $error("init not user pin");
    scan_user_a: assert property ((cfg_state == CPS_USER && !scan_primitive) [*2] |-> !tap_enable)
        else $error("scan port still enabled without scan");
endmodule
bind cps_top cps_checker #(.CLEAR_CYCLES(CLEAR_CYCLES), .WAIT_CYCLES(WAIT_CYCLES)) u_cps_checker (
    .clock, .rst_n, .program_n, .init_o, .init_oe, .cfg_busy_high, .cfg_busy_low, .cfg_error,
    .scan_primitive, .tap_enable, .user_init_o, .user_init_oe, .cfg_state);
`default_nettype wire

// *** sim/cps_source.sv ***
// Far-side source: configuration clock, serial bit and byte bus.
// Assumes one send pulse per byte; the clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module cps_source (
    // Bench control
    input wire logic send,
    input wire logic express,
    input wire logic [7:0] data,
    // Pins toward the device
    output logic cfg_clk,
    output logic sdata,
    output logic [7:0] bus
);
    // One rise per bit, MSB first, or one rise per byte in express
    initial begin
        cfg_clk = 1'b0;
        sdata = 1'b0;
        bus = 8'h00;
        forever begin
            @(posedge send);
            // Step off the core clock edge so pins never move as they are sampled
            #10;
            for (int i = 7; i >= (express ? 7 : 0); i--) begin
                sdata = data[i];
                bus = data;
                #200 cfg_clk = 1'b1;
                #200 cfg_clk = 1'b0;
            end
            // Hold over: show the inverse so stale data never looks valid
            sdata = ~sdata;
            bus = ~bus;
        end
    end
endmodule
`default_nettype wire

// *** sim/test_config_pin_sequencer.sv ***
// Bench: power-up, serial, error, master, express and user-mode scenarios.
// Assumes cps_source as far side and a pull-up on the init wire.
`timescale 1ns/1ps
`default_nettype none
module test_config_pin_sequencer;
    import cps_pkg::*;
    localparam int unsigned CLR = 4;
    localparam int unsigned WT = 8;
    // Bench-driven inputs
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic program_n = 1'b1;
    logic [1:0] mode_pins = 2'h3;
    logic init_hold = 1'b1;
    logic chain_select = 1'b1;
    logic cfg_error = 1'b0;
    logic cfg_done = 1'b0;
    logic scan_primitive = 1'b0;
    logic u = 1'b0;
    logic send = 1'b0;
    logic [7:0] data = 8'h00;
    logic [2:0] tp = 3'h0;
    // Outputs and far-side wires
    logic init_o, init_oe, cfg_clk, sdata, cfg_busy_high, cfg_busy_low, cfg_byte_valid;
    logic tap_enable, tap_tdi, tap_tms, user_tdi, user_tck;
    logic cfg_clock_o, cfg_clock_oe, serial_out, serial_out_oe, cfg_busy_high_oe, cfg_busy_low_oe, tap_tck;
    logic [7:0] fwd_sh = 8'h00;
    logic [7:0] bus, cfg_byte;
    logic [1:0] cfg_mode;
    cps_state_t cfg_state;
    wire logic init_w;
    int fail_count = 0;
    int samples_checked = 0;
    int n_valid = 0;
    // Open drain with pull-up: low when anyone pulls it
    assign init_w = (init_hold || (init_oe && !init_o)) ? 1'b0 : 1'b1;
    always #25 clock = ~clock;
    always @(posedge clock) if (cfg_byte_valid === 1'b1) n_valid <= n_valid + 1;
    // Downstream device: takes forwarded data on each config clock rise
    always @(posedge cfg_clk) fwd_sh <= {fwd_sh[6:0], serial_out};
    cps_top #(.CLEAR_CYCLES(CLR), .WAIT_CYCLES(WT), .HALF_CYCLES(2)) u_cps_top (
        .clock, .rst_n, .program_n, .mode_pins, .init_i(init_w), .init_o, .init_oe,
        .cfg_clock_i(cfg_clk), .cfg_clock_o, .cfg_clock_oe, .serial_in(sdata), .chain_select,
        .cfg_byte_bus(bus), .serial_out, .serial_out_oe, .cfg_busy_high, .cfg_busy_high_oe,
        .cfg_busy_low, .cfg_busy_low_oe, .tdi_pin(tp[0]), .tck_pin(tp[1]), .tms_pin(tp[2]),
        .cfg_error, .cfg_done, .scan_primitive, .cfg_byte, .cfg_byte_valid, .cfg_mode, .cfg_state,
        .user_init_o(u), .user_init_oe(u), .user_high_o(!u), .user_high_oe(!u), .user_low_o(u),
        .user_low_oe(u), .user_dout_o(u), .user_dout_oe(u), .tap_enable, .tap_tdi, .tap_tck,
        .tap_tms, .user_tdi, .user_tck, .user_tms());
    cps_source u_cps_source (.send, .express(mode_pins == 2'h2), .data, .cfg_clk, .sdata, .bus);
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bounded wait for a state; k returns the cycles spent
    task automatic wait_state(input cps_state_t s, input int n, output int k);
        k = 0;
        while (cfg_state !== s && k < n) begin
            cyc(1);
            k++;
        end
        check(8'(cfg_state), 8'(s));
    endtask
    task automatic send_byte(input logic [7:0] d, input logic exp);
        int v0;
        v0 = n_valid;
        data <= d;
        send <= 1'b1;
        cyc(1);
        send <= 1'b0;
        cyc(75);
        check(8'(n_valid - v0), 8'(exp));
        if (exp) check(cfg_byte, d);
    endtask
    // Program pulse with init held low, released once waiting
    task automatic reconfig(input logic [1:0] m);
        int k;
        init_hold <= 1'b1;
        program_n <= 1'b0;
        mode_pins <= m;
        cyc(8);
        program_n <= 1'b1;
        wait_state(CPS_WAIT, 2 * CLR + 8, k);
        init_hold <= 1'b0;
    endtask
    task automatic t_power_up();
        int k;
        cyc(2);
        check(8'(cfg_busy_high), 8'h1);
        check(8'(cfg_busy_low), 8'h0);
        check(8'({init_oe, init_o}), 8'h2);
        check(8'({cfg_busy_high_oe, cfg_busy_low_oe}), 8'h3);
        wait_state(CPS_WAIT, 40, k);
        cyc(20);
        check(8'(cfg_state), 8'(CPS_WAIT));
        init_hold <= 1'b0;
        wait_state(CPS_LOAD, 10, k);
        check(8'(cfg_mode), 8'h3);
    endtask
    task automatic t_serial_error();
        send_byte(8'h1d, 1'b1);
        // Each bit reaches the next device two rises after it arrived
        check(8'(fwd_sh[5:0]), 8'(8'h1d >> 2));
        check(8'({serial_out_oe, cfg_clock_oe}), 8'h2);
        cfg_error <= 1'b1;
        cyc(1);
        cfg_error <= 1'b0;
        cyc(3);
        check(8'(cfg_state), 8'(CPS_ERROR));
        send_byte(8'h62, 1'b0);
        check(8'({init_oe, init_o}), 8'h2);
    endtask
    task automatic t_master();
        int k;
        logic c0;
        reconfig(2'h0);
        wait_state(CPS_LOAD, 40, k);
        check(8'(k >= WT && k <= WT + 8), 8'h1);
        check(8'(cfg_clock_oe), 8'h1);
        c0 = cfg_clock_o;
        cyc(2);
        check(8'(cfg_clock_o), 8'(!c0));
        check(8'(cfg_mode), 8'h0);
    endtask
    task automatic t_express();
        int k;
        reconfig(2'h2);
        wait_state(CPS_LOAD, 10, k);
        chain_select <= 1'b0;
        send_byte(8'h81, 1'b0);
        chain_select <= 1'b1;
        send_byte(8'h7e, 1'b1);
    endtask
    task automatic t_user();
        cfg_done <= 1'b1;
        u <= 1'b1;
        tp <= 3'h3;
        cyc(1);
        cfg_done <= 1'b0;
        cyc(6);
        check(8'(cfg_state), 8'(CPS_USER));
        check(8'({cfg_busy_high, cfg_busy_low}), 8'h1);
        check(8'({cfg_busy_high_oe, cfg_busy_low_oe}), 8'h1);
        check(8'({init_oe, init_o}), 8'h3);
        check(8'({tap_enable, user_tdi, user_tck}), 8'h3);
        scan_primitive <= 1'b1;
        cyc(6);
        check(8'({tap_enable, tap_tdi, tap_tms, user_tdi}), 8'hc);
        check(8'(tap_tck), 8'h1);
    endtask
    task automatic summarize();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        cyc(12);
        rst_n <= 1'b1;
        t_power_up();
        t_serial_error();
        t_master();
        t_express();
        t_user();
        summarize();
    end
    // Watchdog: several times the expected run
    initial begin
        #300000;
        fail_count++;
        summarize();
    end
endmodule
`default_nettype wire
